// ### cfa_autoscan.v
// Flash auto-scan front end of the CRC unit with byte bit-reverse register
`timescale 1ns/1ns
`include "cfa_defs.vh"

module cfa_autoscan (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  output wire sfr_sel,
  output wire cpu_stall,
  output reg [`CFA_ADDR_W-1:0] flash_addr_q,
  output reg flash_rd_q,
  input wire [7:0] flash_rdata,
  input wire flash_rvalid,
  output reg [7:0] crc_feed_data_q,
  output reg crc_feed_q
);

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WAIT = 2'h2;

  // Reset images of the software-visible registers
  localparam [7:0] AUTO_RST = `CFA_AUTO_RESET;
  localparam [7:0] COUNT_RST = `CFA_COUNT_RESET;
  localparam [7:0] FLIP_RST = `CFA_FLIP_RESET;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg auto_en_q;
  reg auto_en_d;
  reg done_q;
  reg done_d;
  reg [`CFA_START_MSB:0] start_q;
  reg [`CFA_START_MSB:0] start_d;
  reg [`CFA_COUNT_MSB:0] count_q;
  reg [`CFA_COUNT_MSB:0] count_d;
  reg [7:0] flip_q;
  reg [7:0] flip_d;
  reg [`CFA_ADDR_W-1:0] end_addr_q;
  reg [`CFA_ADDR_W-1:0] end_addr_d;
  reg [`CFA_ADDR_W-1:0] flash_addr_d;
  reg flash_rd_d;
  reg [7:0] crc_feed_data_d;
  reg crc_feed_d;
  wire wr_auto;
  wire wr_cnt;
  wire wr_flip;
  wire wr_ctrl;
  wire scan_go;
  wire last_byte;
  wire [`CFA_ADDR_W-`CFA_SECTOR_SHIFT-1:0] sector_sum;
  wire [`CFA_ADDR_W-1:0] first_addr;
  wire [`CFA_ADDR_W-1:0] last_byte_addr;
  wire [7:0] flip_rev;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  assign wr_auto = sfr_wr && (sfr_addr == `CFA_OFS_AUTO_CTRL);
  assign wr_cnt = sfr_wr && (sfr_addr == `CFA_OFS_SECTOR_COUNT);
  assign wr_flip = sfr_wr && (sfr_addr == `CFA_OFS_BIT_REVERSE);
  assign wr_ctrl = sfr_wr && (sfr_addr == `CFA_OFS_CRC_CTRL);
  assign sfr_sel = (sfr_addr == `CFA_OFS_AUTO_CTRL) || (sfr_addr == `CFA_OFS_SECTOR_COUNT) ||
                   (sfr_addr == `CFA_OFS_BIT_REVERSE);
  // Read strobe has no side effect here: no register clears on read

  ////////////////////////////////////////////////////////////////////////////
  // Sector arithmetic: a sector spans 512 bytes, so a base address is the
  // sector number with nine zero bits below it
  assign first_addr = {2'h0, start_q, `CFA_SECTOR_FIRST};
  // Seven bits hold the largest start plus count without wrapping
  assign sector_sum = {2'h0, start_q} + {1'h0, count_q};
  // The sector at the last base address is scanned to its final byte
  assign last_byte_addr = {sector_sum, `CFA_SECTOR_LAST};

  // Bit reverse is pure wiring on the stored byte
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_rev
      assign flip_rev[gi] = flip_q[7-gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always @* begin
    auto_en_d = auto_en_q;
    start_d = start_q;
    count_d = count_q;
    flip_d = flip_q;
    // Bit 6 is scan status and bit 5 is reserved, so neither stores write data
    if (wr_auto) begin
      auto_en_d = sfr_wdata[`CFA_AUTO_EN_BIT];
      start_d = sfr_wdata[`CFA_START_MSB:0];
    end
    if (wr_cnt) begin
      // The two upper bits are dropped and read back as zero
      count_d = sfr_wdata[`CFA_COUNT_MSB:0];
    end
    if (wr_flip) begin
      flip_d = sfr_wdata;
    end
  end

  // No guard against writes mid-scan: the stalled CPU cannot issue them
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      auto_en_q <= AUTO_RST[`CFA_AUTO_EN_BIT];
      start_q <= AUTO_RST[`CFA_START_MSB:0];
      count_q <= COUNT_RST[`CFA_COUNT_MSB:0];
      flip_q <= FLIP_RST;
    end else begin
      auto_en_q <= auto_en_d;
      start_q <= start_d;
      count_q <= count_d;
      flip_q <= flip_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always @* begin
    case (sfr_addr)
      `CFA_OFS_AUTO_CTRL: sfr_rdata = {auto_en_q, done_q, 1'b0, start_q};
      `CFA_OFS_SECTOR_COUNT: sfr_rdata = {2'b00, count_q};
      `CFA_OFS_BIT_REVERSE: sfr_rdata = flip_rev;
      default: sfr_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan engine
  // One byte in flight at a time: the Flash port may answer after any number
  // of cycles and no queue is needed, at the cost of a cycle per byte
  assign cpu_stall = (state_q != ST_IDLE);
  assign scan_go = wr_ctrl && auto_en_q;
  // Compare against the final byte so the last sector is taken whole
  assign last_byte = (flash_addr_q == end_addr_q);

  always @* begin
    state_d = state_q;
    done_d = done_q;
    flash_addr_d = flash_addr_q;
    end_addr_d = end_addr_q;
    // Strobes default low so each stands for exactly one cycle
    flash_rd_d = 1'b0;
    crc_feed_d = 1'b0;
    crc_feed_data_d = crc_feed_data_q;
    case (state_q)
      ST_IDLE: begin
        // With auto-scan off a control write is left to the CRC engine alone
        if (scan_go) begin
          flash_addr_d = first_addr;
          end_addr_d = last_byte_addr;
          done_d = 1'b0;
          flash_rd_d = 1'b1;
          state_d = ST_WAIT;
        end
      end
      ST_READ: begin
        flash_rd_d = 1'b1;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (flash_rvalid) begin
          // One feed pulse per byte, as a data-input write would give
          crc_feed_d = 1'b1;
          crc_feed_data_d = flash_rdata;
          if (last_byte) begin
            done_d = 1'b1;
            state_d = ST_IDLE;
          end else begin
            flash_addr_d = flash_addr_q + 16'h0001;
            state_d = ST_READ;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Every register reloads on each clock; holding is done in the next-value logic
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      done_q <= AUTO_RST[`CFA_DONE_BIT];
      flash_addr_q <= {`CFA_ADDR_W{1'b0}};
      end_addr_q <= {`CFA_ADDR_W{1'b0}};
      flash_rd_q <= 1'b0;
      crc_feed_q <= 1'b0;
      crc_feed_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      done_q <= done_d;
      flash_addr_q <= flash_addr_d;
      end_addr_q <= end_addr_d;
      flash_rd_q <= flash_rd_d;
      crc_feed_q <= crc_feed_d;
      crc_feed_data_q <= crc_feed_data_d;
    end
  end

endmodule

// ### cfa_autoscan_properties.sv
// Port checks for the auto-scan block
`timescale 1ns/1ns
module cfa_props(
  input wire core_clk,
  input wire resetn,
  input wire sfr_wr,
  input wire cpu_stall,
  input wire flash_rd_q,
  input wire flash_rvalid,
  input wire crc_feed_q,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire [7:0] flash_rdata,
  input wire [7:0] crc_feed_data_q,
  input wire [15:0] flash_addr_q
);
  reg en_q;
  wire go = sfr_wr && sfr_addr == 8'h91 && !cpu_stall;
  wire a96 = sfr_addr == 8'h96;
  always @(posedge core_clk or negedge resetn)
    if (!resetn) en_q <= 0;
    else if (sfr_wr && a96) en_q <= sfr_wdata[7];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  scan_start_a: assert property (go && en_q |=> cpu_stall && flash_rd_q) else $error("bad");
  no_start_a: assert property (go && !en_q |=> !cpu_stall) else $error("bad");
  busy_done_a: assert property (cpu_stall && a96 |-> !sfr_rdata[6]) else $error("bad");
  idle_done_a: assert property (!cpu_stall && a96 |-> sfr_rdata[6]) else $error("bad");
  count_top_a: assert property (sfr_addr == 8'h97 |-> !sfr_rdata[7:6]) else $error("bad");
  flip_read_a: assert property (sfr_wr && sfr_addr == 8'h95 ##1 sfr_addr == 8'h95
    |-> sfr_rdata == {<<{$past(sfr_wdata)}}) else $error("bad");
  feed_byte_a: assert property (flash_rvalid && cpu_stall |=> crc_feed_q
    && crc_feed_data_q == $past(flash_rdata)) else $error("bad");
  addr_step_a: assert property (flash_rd_q && !$rose(cpu_stall) |->
    flash_addr_q == $past(flash_addr_q, 2) + 16'h0001) else $error("bad");
  cover property ($fell(cpu_stall));
  cover property (go && !en_q);
  cover property (a96 && sfr_wr);
endmodule
bind cfa_autoscan cfa_props cfa_props_i(
  .core_clk(core_clk),
  .resetn(resetn),
  .sfr_wr(sfr_wr),
  .cpu_stall(cpu_stall),
  .flash_rd_q(flash_rd_q),
  .flash_rvalid(flash_rvalid),
  .crc_feed_q(crc_feed_q),
  .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .flash_rdata(flash_rdata),
  .crc_feed_data_q(crc_feed_data_q),
  .flash_addr_q(flash_addr_q)
);

// ### cfa_autoscan_tb.sv
// Register and auto-scan test
`timescale 1ns/1ns
module cfa_autoscan_tb;
  logic core_clk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, cpu_stall, flash_rd_q, flash_rvalid;
  logic crc_feed_q, sfr_sel;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, flash_rdata, crc_feed_data_q;
  logic [15:0] flash_addr_q, a;
  int fail_count = 0, checks_done = 0, n, base;
  cfa_autoscan cfa_autoscan_i(
    .core_clk(core_clk),
    .resetn(resetn),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_sel(sfr_sel),
    .cpu_stall(cpu_stall),
    .flash_addr_q(flash_addr_q),
    .flash_rd_q(flash_rd_q),
    .flash_rdata(flash_rdata),
    .flash_rvalid(flash_rvalid),
    .crc_feed_data_q(crc_feed_data_q),
    .crc_feed_q(crc_feed_q)
  );
  cfa_flash cfa_flash_i(
    .core_clk(core_clk),
    .flash_rd_q(flash_rd_q),
    .flash_addr_q(flash_addr_q),
    .flash_rdata(flash_rdata),
    .flash_rvalid(flash_rvalid)
  );
  initial forever #5 core_clk = ~core_clk;
  task chk(logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One idle edge after each write keeps strobe changes in separate time steps
  task w(logic [7:0] ad, d);
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {ad, d, 2'b10};
    @(posedge core_clk) #1 sfr_wr = 0;
    @(posedge core_clk) #1;
  endtask
  task r(logic [7:0] ad, e);
    {sfr_addr, sfr_rd} = {ad, 1'b1};
    #1 chk(sfr_rdata, e);
    chk(sfr_sel, ad >= 8'h95 && ad <= 8'h97);
    @(posedge core_clk) #1;
  endtask
  task finish_test;
    $display("Checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) if (crc_feed_q) begin
    a = base + n++;
    chk(crc_feed_data_q, a[7:0] ^ a[15:8]);
  end
  task scan(logic [4:0] st, logic [5:0] c);
    base = st * 512;
    n = 0;
    w(8'h97, {2'h0, c});
    w(8'h96, {3'h4, st});
    w(8'h91, 8'h00);
    // Watch the status register while the scan runs
    sfr_addr = 8'h96;
    #1 chk(sfr_rdata[6], 1'b0);
    chk(cpu_stall, 1'b1);
    for (int i = 0; i < 9000 && cpu_stall !== 1'b0; i++) @(posedge core_clk) #1;
    if (cpu_stall !== 1'b0) begin
      fail_count++;
      $display("Error %0t scan did not finish", $time);
      finish_test;
    end
    r(8'h96, {3'h6, st});
    chk(n, (c + 1) * 512);
    w(8'h96, {3'h0, st});
    $display("scan done");
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1 resetn = 1;
    r(8'h96, 8'h40);
    r(8'h97, 8'h00);
    r(8'h95, 8'h00);
    r(8'h90, 8'h00);
    w(8'h95, 8'hC0);
    r(8'h95, 8'h03);
    w(8'h95, 8'h05);
    r(8'h95, 8'hA0);
    w(8'h97, 8'hFF);
    r(8'h97, 8'h3F);
    w(8'h96, 8'h03);
    w(8'h91, 8'h00);
    chk(cpu_stall, 1'b0);
    r(8'h96, 8'h43);
    $display("regs done");
    scan(5'h02, 6'h01);
    scan(5'h1F, 6'h00);
    finish_test;
  end
endmodule

// ### cfa_defs.vh
// Register offsets, field positions, reset values and scan constants for the auto-scan block
`ifndef CFA_DEFS_VH
`define CFA_DEFS_VH
`define CFA_OFS_BIT_REVERSE 8'h95
`define CFA_OFS_AUTO_CTRL 8'h96
`define CFA_OFS_SECTOR_COUNT 8'h97
`define CFA_OFS_CRC_CTRL 8'h91
`define CFA_AUTO_EN_BIT 7
`define CFA_DONE_BIT 6
`define CFA_RSVD_BIT 5
`define CFA_START_MSB 4
`define CFA_COUNT_MSB 5
`define CFA_AUTO_RESET 8'h40
`define CFA_COUNT_RESET 8'h00
`define CFA_FLIP_RESET 8'h00
`define CFA_SECTOR_SHIFT 9
`define CFA_SECTOR_FIRST 9'h000
`define CFA_SECTOR_LAST 9'h1FF
`define CFA_ADDR_W 16
`endif

// ### cfa_flash_model.sv
// Flash read port model; odd addresses answer two cycles late
`timescale 1ns/1ns
module cfa_flash(input wire core_clk, flash_rd_q, input wire [15:0] flash_addr_q,
  output logic [7:0] flash_rdata = 0, output logic flash_rvalid = 0);
  always @(posedge core_clk) begin
    flash_rvalid <= 0;
    flash_rdata <= ~flash_rdata;
    if (flash_rd_q === 1) begin
      repeat (2 * flash_addr_q[0]) @(posedge core_clk);
      {flash_rvalid, flash_rdata} <= {1'b1, flash_addr_q[7:0] ^ flash_addr_q[15:8]};
    end
  end
endmodule
